// file: shared/txo_pkg.sv
// package: constants and types for the channel output state block
package txo_pkg;

    localparam int OFF_W   = 7;
    localparam int WAVE_W  = 2;
    localparam int WIDTH_W = 9;
    localparam int DCODE_W = 5;
    localparam int KCNT_W  = 9;
    localparam int IDX_W   = 3;
    localparam int N_WAVES = 4;
    localparam int N_KCODE = 23;

    // table index: bit 2 picks the side, bits 1:0 the waveform
    localparam int          SIDE_BIT  = 2;
    localparam logic        SIDE_P    = 1'b0;
    localparam logic        SIDE_N    = 1'b1;
    localparam logic [6:0]  OFF_RST   = 7'h00;

    localparam logic [8:0]  MIN_WIDTH = 9'h002;
    localparam logic [9:0]  MIN_GAP   = 10'h002;
    localparam logic [7:0]  SUM_ONE   = 8'h01;
    localparam logic [7:0]  SUM_PWM   = 8'h02;
    localparam logic [8:0]  PHASE_ONE = 9'h001;
    localparam logic [8:0]  PHASE_RST = 9'h000;

    // switch-on delay table, in core clock cycles
    localparam logic [4:0]  DCODE_MAX = 5'h16;
    localparam logic [8:0]  K_MAX     = 9'h120;
    localparam logic [8:0]  K_ONE     = 9'h001;
    localparam logic [8:0]  K_TABLE [0:N_KCODE-1] = '{
        9'h001, 9'h008, 9'h00c, 9'h010, 9'h014, 9'h018, 9'h024, 9'h028,
        9'h030, 9'h03c, 9'h040, 9'h048, 9'h050, 9'h060, 9'h064, 9'h078,
        9'h080, 9'h090, 9'h0a0, 9'h0c0, 9'h0c8, 9'h0f0, 9'h120
    };

    typedef enum logic [2:0] {
        OUT_HIZ,
        OUT_RTZ,
        OUT_POS,
        OUT_NEG,
        OUT_RX,
        OUT_CWP,
        OUT_CWN
    } txo_out_e;

endpackage

// file: shared/txo_tbl_if.sv
// interface: off-time table access between controller and table memory
`timescale 1ns/100ps
interface txo_tbl_if;
    logic                        wr_en;
    logic [txo_pkg::IDX_W-1:0]   wr_index;
    logic [txo_pkg::OFF_W-1:0]   wr_data;
    logic [txo_pkg::WAVE_W-1:0]  wave_sel;
    logic [txo_pkg::IDX_W-1:0]   rd_index;
    logic [txo_pkg::OFF_W-1:0]   p_off;
    logic [txo_pkg::OFF_W-1:0]   n_off;
    logic [txo_pkg::OFF_W-1:0]   rd_data;

    modport ctrl (output wr_en, wr_index, wr_data, wave_sel, rd_index,
                  input  p_off, n_off, rd_data);
    modport mem  (input  wr_en, wr_index, wr_data, wave_sel, rd_index,
                  output p_off, n_off, rd_data);
endinterface

// file: src/txo_offtime_mem.sv
// memory: eight off-time values, registered reads for both sides
`timescale 1ns/100ps
module txo_offtime_mem (
    input  wire logic clk_in,
    input  wire logic rst_in,
    txo_tbl_if.mem    tbl
);
    logic [txo_pkg::OFF_W-1:0] mem [0:2*txo_pkg::N_WAVES-1];
    wire  [txo_pkg::IDX_W-1:0] p_idx = {txo_pkg::SIDE_P, tbl.wave_sel};
    wire  [txo_pkg::IDX_W-1:0] n_idx = {txo_pkg::SIDE_N, tbl.wave_sel};

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < 2*txo_pkg::N_WAVES; i++) begin
                mem[i] <= txo_pkg::OFF_RST;
            end
        end else if (tbl.wr_en) begin
            mem[tbl.wr_index] <= tbl.wr_data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tbl.p_off   <= txo_pkg::OFF_RST;
            tbl.n_off   <= txo_pkg::OFF_RST;
            tbl.rd_data <= txo_pkg::OFF_RST;
        end else begin
            tbl.p_off   <= mem[p_idx];
            tbl.n_off   <= mem[n_idx];
            tbl.rd_data <= mem[tbl.rd_index];
        end
    end
endmodule

// file: src/txo_rx_delay.sv
// timer: receive-switch turn-on delay after a receive request
`timescale 1ns/100ps
module txo_rx_delay (
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    input  wire logic                        request_in,
    input  wire logic [txo_pkg::DCODE_W-1:0] code_in,
    output logic                             done_out
);
    logic [txo_pkg::KCNT_W-1:0] cnt;
    wire  [txo_pkg::KCNT_W-1:0] k_sel;
    wire  [txo_pkg::KCNT_W-1:0] next_cnt = cnt + txo_pkg::K_ONE;

    // codes past the table clamp to the longest delay
    assign k_sel = (code_in > txo_pkg::DCODE_MAX) ? txo_pkg::K_MAX
                                                  : txo_pkg::K_TABLE[code_in];

    always_ff @(posedge clk_in) begin
        if (rst_in || !request_in) begin
            cnt      <= '0;
            done_out <= 1'b0;
        end else if (!done_out) begin
            cnt      <= next_cnt;
            done_out <= (next_cnt >= k_sel);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_k_clamp;
        (code_in > txo_pkg::DCODE_MAX) |-> (k_sel == 9'h120);
    endproperty
    a_k_clamp: assert property (p_k_clamp) else $error("delay code not clamped");

    property p_done_time;
        $rose(done_out) |-> ($past(cnt) + 9'h001 >= $past(k_sel)) && $past(request_in);
    endproperty
    a_done_time: assert property (p_done_time) else $error("switch on before delay");
endmodule

// file: src/txo_channel.sv
// top: per-channel transmit output state decode with pwm off-times
//
// Overview of operation
// - delay codes above 10110b use 288 cycles
// - four P off-times, picked by waveform select
// - four N off-times, picked by waveform select
// - invert swaps which switch each off-time gates
// - off-time sum of one forces return-to-zero
// - width minus twice off-time below two forces zero
// - zero off-times need width at least two
// - pulsed mode drives zero, positive or negative
// - invert swaps positive and negative drive results
// - both drives high enters the receive state
// - continuous wave gives high-z, cw levels, receive
// - disabled or program mode gives high-z, damper
// - high-z turns the p and n output switches off
// - receive indicator closes switches after delay; a parked channel ignores it
// - width below two forces return-to-zero
`timescale 1ns/100ps
module txo_channel (
    input  wire logic                            clk_in,
    input  wire logic                            rst_in,
    input  wire logic                            enable_in,
    input  wire logic                            transmit_or_program_select_in,
    input  wire logic                            continuous_wave_select_in,
    input  wire logic                            output_invert_in,
    input  wire logic                            positive_drive_in,
    input  wire logic                            negative_drive_in,
    input  wire logic [txo_pkg::WAVE_W-1:0]      wave_select_in,
    input  wire logic [txo_pkg::WIDTH_W-1:0]     half_cycle_width_in,
    input  wire logic [txo_pkg::DCODE_W-1:0]     rx_switch_delay_code_in,
    input  wire logic                            receive_indicator_in,
    input  wire logic                            reg_wr_en_in,
    input  wire logic [txo_pkg::IDX_W-1:0]       reg_wr_index_in,
    input  wire logic [txo_pkg::OFF_W-1:0]       reg_wr_data_in,
    input  wire logic [txo_pkg::IDX_W-1:0]       reg_rd_index_in,
    output logic [txo_pkg::OFF_W-1:0]            reg_rd_data_out,
    output txo_pkg::txo_out_e                    out_state_out,
    output logic                                 p_fet_on_out,
    output logic                                 n_fet_on_out,
    output logic                                 zero_return_switch_out,
    output logic                                 receive_switch_out,
    output logic                                 receive_damper_out,
    output logic                                 receive_indicator_out,
    output logic                                 cw_logic_enable_out,
    output logic                                 cw_positive_level_out,
    output logic                                 cw_negative_level_out,
    output logic                                 force_rtz_out
);
    txo_tbl_if tbl ();

    txo_pkg::txo_out_e          next_state;
    logic [txo_pkg::WIDTH_W-1:0] phase;
    logic [txo_pkg::WIDTH_W-1:0] next_phase;
    logic                        rx_done;

    // table access
    assign tbl.wr_en    = reg_wr_en_in;
    assign tbl.wr_index = reg_wr_index_in;
    assign tbl.wr_data  = reg_wr_data_in;
    assign tbl.wave_sel = wave_select_in;
    assign tbl.rd_index = reg_rd_index_in;

    txo_offtime_mem u_mem (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .tbl    (tbl)
    );

    // mode decode
    wire active    = enable_in && transmit_or_program_select_in;
    wire cw_mode   = active && continuous_wave_select_in;
    wire both_dr   = positive_drive_in && negative_drive_in;
    wire none_dr   = !positive_drive_in && !negative_drive_in;
    wire drive_pos = output_invert_in ? negative_drive_in : positive_drive_in;
    wire drive_neg = output_invert_in ? positive_drive_in : negative_drive_in;

    // legality of the selected off-times against the half-cycle width
    wire [7:0] off_sum   = {1'b0, tbl.p_off} + {1'b0, tbl.n_off};
    wire [9:0] width_ext = {1'b0, half_cycle_width_in};
    wire [9:0] lim_p     = {2'b00, tbl.p_off, 1'b0} + txo_pkg::MIN_GAP;
    wire [9:0] lim_n     = {2'b00, tbl.n_off, 1'b0} + txo_pkg::MIN_GAP;
    wire bad_sum_one = (off_sum == txo_pkg::SUM_ONE);
    wire bad_margin  = (off_sum >= txo_pkg::SUM_PWM)
                    && ((width_ext < lim_p) || (width_ext < lim_n));
    wire bad_zero    = (off_sum == 8'h00)
                    && (half_cycle_width_in < txo_pkg::MIN_WIDTH);
    wire bad_width   = (half_cycle_width_in < txo_pkg::MIN_WIDTH);
    wire force_rtz   = bad_sum_one || bad_margin || bad_zero || bad_width;

    // with invert, each off-time gates the opposite switch
    wire [txo_pkg::OFF_W-1:0] off_for_p = output_invert_in ? tbl.n_off : tbl.p_off;
    wire [txo_pkg::OFF_W-1:0] off_for_n = output_invert_in ? tbl.p_off : tbl.n_off;

    // output state selection
    always_comb begin
        next_state = txo_pkg::OUT_HIZ;
        if (!active) begin
            next_state = txo_pkg::OUT_HIZ;
        end else if (both_dr) begin
            next_state = txo_pkg::OUT_RX;
        end else if (continuous_wave_select_in) begin
            case ({drive_pos, drive_neg})
                2'b10:   next_state = txo_pkg::OUT_CWP;
                2'b01:   next_state = txo_pkg::OUT_CWN;
                default: next_state = txo_pkg::OUT_HIZ;
            endcase
        end else begin
            case ({drive_pos, drive_neg})
                2'b10:   next_state = force_rtz ? txo_pkg::OUT_RTZ : txo_pkg::OUT_POS;
                2'b01:   next_state = force_rtz ? txo_pkg::OUT_RTZ : txo_pkg::OUT_NEG;
                default: next_state = txo_pkg::OUT_RTZ;
            endcase
        end
    end

    // half-cycle phase, restarted at every state change
    wire phase_wrap = (phase + txo_pkg::PHASE_ONE >= half_cycle_width_in);
    always_comb begin
        if (next_state != out_state_out || phase_wrap) begin
            next_phase = txo_pkg::PHASE_RST;
        end else begin
            next_phase = phase + txo_pkg::PHASE_ONE;
        end
    end

    // a switch conducts only between its leading and trailing off-time
    wire [9:0] phase_ext = {1'b0, next_phase};
    wire [9:0] p_lo      = {3'b000, off_for_p};
    wire [9:0] n_lo      = {3'b000, off_for_n};
    wire       p_window  = (phase_ext >= p_lo) && (phase_ext < width_ext - p_lo);
    wire       n_window  = (phase_ext >= n_lo) && (phase_ext < width_ext - n_lo);
    wire next_p_fet = (next_state == txo_pkg::OUT_POS) && p_window;
    wire next_n_fet = (next_state == txo_pkg::OUT_NEG) && n_window;

    // receive request: own receive state or the shared indicator; a parked channel ignores it
    wire next_rx_state = (next_state == txo_pkg::OUT_RX);
    wire rx_request    = next_rx_state || (receive_indicator_in && active);

    txo_rx_delay u_delay (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .request_in (rx_request),
        .code_in    (rx_switch_delay_code_in),
        .done_out   (rx_done)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            out_state_out <= txo_pkg::OUT_HIZ;
            phase         <= txo_pkg::PHASE_RST;
            p_fet_on_out  <= 1'b0;
            n_fet_on_out  <= 1'b0;
        end else begin
            out_state_out <= next_state;
            phase         <= next_phase;
            p_fet_on_out  <= next_p_fet;
            n_fet_on_out  <= next_n_fet;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            receive_damper_out    <= 1'b1;
            receive_indicator_out <= 1'b0;
            cw_logic_enable_out   <= 1'b0;
            cw_positive_level_out <= 1'b0;
            cw_negative_level_out <= 1'b0;
            force_rtz_out         <= 1'b0;
            reg_rd_data_out       <= txo_pkg::OFF_RST;
        end else begin
            receive_damper_out    <= !rx_request;
            // the cw receive state closes switches but raises no indicator
            receive_indicator_out <= next_rx_state && !continuous_wave_select_in;
            cw_logic_enable_out   <= cw_mode;
            cw_positive_level_out <= (next_state == txo_pkg::OUT_CWP);
            cw_negative_level_out <= (next_state == txo_pkg::OUT_CWN);
            force_rtz_out         <= force_rtz;
            reg_rd_data_out       <= tbl.rd_data;
        end
    end

    // both switches follow the delayed receive request
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            receive_switch_out     <= 1'b0;
            zero_return_switch_out <= 1'b0;
        end else begin
            receive_switch_out     <= rx_done && rx_request;
            zero_return_switch_out <= rx_done && rx_request;
        end
    end

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    wire pulsed_single = active && !continuous_wave_select_in
                      && (positive_drive_in != negative_drive_in);

    property p_sum_one;
        pulsed_single && bad_sum_one |=> out_state_out == txo_pkg::OUT_RTZ;
    endproperty
    a_sum_one: assert property (p_sum_one) else $error("sum one not forced to zero");

    property p_margin;
        pulsed_single && (off_sum >= 8'h02) && (width_ext < lim_p)
            |=> out_state_out == txo_pkg::OUT_RTZ;
    endproperty
    a_margin: assert property (p_margin) else $error("short margin not forced to zero");

    property p_zero_off;
        pulsed_single && (off_sum == 8'h00) && (half_cycle_width_in >= 9'h002)
            |=> out_state_out != txo_pkg::OUT_RTZ;
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("legal zero off-time blocked");

    property p_width;
        pulsed_single && (half_cycle_width_in < 9'h002)
            |=> out_state_out == txo_pkg::OUT_RTZ && !p_fet_on_out && !n_fet_on_out;
    endproperty
    a_width: assert property (p_width) else $error("short width not forced to zero");

    property p_pulse_pos;
        pulsed_single && !force_rtz && positive_drive_in && !output_invert_in
            |=> out_state_out == txo_pkg::OUT_POS;
    endproperty
    a_pulse_pos: assert property (p_pulse_pos) else $error("positive drive not taken");

    property p_invert;
        pulsed_single && !force_rtz && positive_drive_in && output_invert_in
            |=> out_state_out == txo_pkg::OUT_NEG;
    endproperty
    a_invert: assert property (p_invert) else $error("invert did not swap drive");

    property p_rx;
        active && both_dr && !continuous_wave_select_in
            |=> out_state_out == txo_pkg::OUT_RX && receive_indicator_out
                && !receive_damper_out;
    endproperty
    a_rx: assert property (p_rx) else $error("receive state not entered");

    property p_cw_idle;
        cw_mode && none_dr |=> out_state_out == txo_pkg::OUT_HIZ && cw_logic_enable_out;
    endproperty
    a_cw_idle: assert property (p_cw_idle) else $error("cw idle not high-z");

    property p_off;
        !active |=> out_state_out == txo_pkg::OUT_HIZ && receive_damper_out
                    && !cw_logic_enable_out;
    endproperty
    a_off: assert property (p_off) else $error("disabled channel not high-z");

    property p_hiz;
        out_state_out == txo_pkg::OUT_HIZ |-> !p_fet_on_out && !n_fet_on_out;
    endproperty
    a_hiz: assert property (p_hiz) else $error("switch on in high-z");

    property p_p_off;
        $rose(p_fet_on_out) && $stable(tbl.p_off) && $stable(tbl.n_off)
            |-> {1'b0, phase} >= {3'b000, off_for_p};
    endproperty
    a_p_off: assert property (p_p_off) else $error("p switch on inside off-time");

    property p_rx_switch;
        !rx_request |=> !receive_switch_out ##1 !receive_switch_out;
    endproperty
    a_rx_switch: assert property (p_rx_switch) else $error("switch on without request");

    property p_neg_drive;
        pulsed_single && !force_rtz && negative_drive_in && !output_invert_in
            |=> out_state_out == txo_pkg::OUT_NEG;
    endproperty
    a_neg_drive: assert property (p_neg_drive) else $error("neg drive not taken");

    property p_idle_rtz;
        active && !continuous_wave_select_in && none_dr
            |=> out_state_out == txo_pkg::OUT_RTZ;
    endproperty
    a_idle_rtz: assert property (p_idle_rtz) else $error("idle not at zero");

    property p_invert_neg;
        pulsed_single && !force_rtz && negative_drive_in && output_invert_in
            |=> out_state_out == txo_pkg::OUT_POS;
    endproperty
    a_invert_neg: assert property (p_invert_neg) else $error("invert kept drive");

    property p_cw_pos;
        cw_mode && (positive_drive_in != negative_drive_in)
            && (positive_drive_in != output_invert_in)
            |=> out_state_out == txo_pkg::OUT_CWP && cw_positive_level_out;
    endproperty
    a_cw_pos: assert property (p_cw_pos) else $error("cw positive missing");

    property p_cw_neg;
        cw_mode && (positive_drive_in != negative_drive_in)
            && (positive_drive_in == output_invert_in)
            |=> out_state_out == txo_pkg::OUT_CWN && cw_negative_level_out;
    endproperty
    a_cw_neg: assert property (p_cw_neg) else $error("cw negative missing");

    property p_cw_rx;
        cw_mode && both_dr
            |=> out_state_out == txo_pkg::OUT_RX && !receive_indicator_out
                && !receive_damper_out;
    endproperty
    a_cw_rx: assert property (p_cw_rx) else $error("cw receive state wrong");

    property p_off_switch;
        !active
            |=> !receive_switch_out && !zero_return_switch_out
                && !p_fet_on_out && !n_fet_on_out;
    endproperty
    a_off_switch: assert property (p_off_switch) else $error("parked switch on");

    property p_rtz_fets;
        out_state_out == txo_pkg::OUT_RTZ
            |-> !p_fet_on_out && !n_fet_on_out;
    endproperty
    a_rtz_fets: assert property (p_rtz_fets) else $error("rail on at zero");

    property p_n_off;
        $rose(n_fet_on_out) && $stable(tbl.p_off) && $stable(tbl.n_off)
            |-> {1'b0, phase} >= {3'b000, off_for_n};
    endproperty
    a_n_off: assert property (p_n_off) else $error("n switch on inside off-time");

    property p_p_tail;
        p_fet_on_out && $stable(tbl.p_off) && $stable(tbl.n_off)
            && $stable(output_invert_in) && $stable(half_cycle_width_in)
            |-> {1'b0, phase} + {3'b000, off_for_p} < width_ext;
    endproperty
    a_p_tail: assert property (p_p_tail) else $error("p on in trailing off");

    property p_n_tail;
        n_fet_on_out && $stable(tbl.p_off) && $stable(tbl.n_off)
            && $stable(output_invert_in) && $stable(half_cycle_width_in)
            |-> {1'b0, phase} + {3'b000, off_for_n} < width_ext;
    endproperty
    a_n_tail: assert property (p_n_tail) else $error("n on in trailing off");

    property p_rx_hold;
        receive_switch_out && rx_request
            |=> receive_switch_out && zero_return_switch_out;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("switch dropped early");

    property p_flag_clear;
        (off_sum == 8'h00) && (half_cycle_width_in >= 9'h002)
            |=> !force_rtz_out;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("legal zero flagged");

    property p_rx_first;
        !rx_request ##1 rx_request
            |=> !receive_switch_out;
    endproperty
    a_rx_first: assert property (p_rx_first) else $error("switch with no delay");
endmodule

// file: dv/txo_ctrl_model.sv
// controller model: drives mode, waveform select and drive pins of one channel
`timescale 1ns/100ps
module txo_ctrl_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] cmd_in,
    output logic      [7:0] pins_out
);
    // pins_out: {wave[1:0], enable, transmit_or_program_select, cw, invert, positive, negative}
    wire mode_change;
    wire driving;

    assign mode_change = cmd_in[7:2] != pins_out[7:2];
    assign driving     = pins_out[1:0] != 2'b00;

    // a burst is closed for one cycle before mode or wave moves
    always @(posedge clk_in) begin
        if (mode_change && driving) begin
            pins_out <= {pins_out[7:2], 2'b00};
        end else begin
            pins_out <= cmd_in;
        end
    end
endmodule

// file: dv/testbench.sv
// testbench: output state decode, receive delay, off-time table and legality
`timescale 1ns/100ps
module testbench;
    logic             clk_in = 1'b0;
    logic             rst_in = 1'b1;
    logic [7:0]       cmd    = 8'h00;
    logic [7:0]       pins;
    logic [8:0]       width  = 9'h014;
    logic [4:0]       dcode  = 5'h00;
    logic             rx_ind = 1'b0;
    logic             wr_en  = 1'b0;
    logic [2:0]       wr_idx = 3'h0;
    logic [2:0]       rd_idx = 3'h0;
    logic [6:0]       wr_dat = 7'h00;
    logic [6:0]       rd_data;
    txo_pkg::txo_out_e st;
    logic             p_fet, n_fet, zsw, rsw, damp, ind_out, cw_en, frtz, cwp, cwn;
    int               mismatches = 0;
    int               checked = 0;

    always #50 clk_in = ~clk_in;

    txo_ctrl_model ctrl (.clk_in(clk_in), .cmd_in(cmd), .pins_out(pins));

    txo_channel DUT (
        .clk_in(clk_in), .rst_in(rst_in), .enable_in(pins[5]),
        .transmit_or_program_select_in(pins[4]), .continuous_wave_select_in(pins[3]),
        .output_invert_in(pins[2]), .positive_drive_in(pins[1]),
        .negative_drive_in(pins[0]), .wave_select_in(pins[7:6]),
        .half_cycle_width_in(width), .rx_switch_delay_code_in(dcode),
        .receive_indicator_in(rx_ind), .reg_wr_en_in(wr_en), .reg_wr_index_in(wr_idx),
        .reg_wr_data_in(wr_dat), .reg_rd_index_in(rd_idx), .reg_rd_data_out(rd_data),
        .out_state_out(st), .p_fet_on_out(p_fet), .n_fet_on_out(n_fet),
        .zero_return_switch_out(zsw), .receive_switch_out(rsw),
        .receive_damper_out(damp), .receive_indicator_out(ind_out),
        .cw_logic_enable_out(cw_en), .cw_positive_level_out(cwp),
        .cw_negative_level_out(cwn), .force_rtz_out(frtz)
    );

    task automatic report_and_stop();
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic setm(input logic [7:0] c);
        @(posedge clk_in);
        cmd <= c;
        repeat (6) @(posedge clk_in);
        #1;
    endtask

    task automatic wr(input logic [2:0] i, input logic [6:0] d);
        @(posedge clk_in);
        wr_en <= 1'b1;
        wr_idx <= i;
        wr_dat <= d;
        @(posedge clk_in);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] i, input logic [6:0] e);
        @(posedge clk_in);
        rd_idx <= i;
        repeat (3) @(posedge clk_in);
        #1 chk(16'(rd_data), 16'(e));
    endtask

    // m = {cw, invert, positive, negative}
    function automatic txo_pkg::txo_out_e exp_st(input logic [3:0] m);
        logic p;
        logic n;
        p = m[2] ? m[0] : m[1];
        n = m[2] ? m[1] : m[0];
        if (m[1] && m[0]) return txo_pkg::OUT_RX;
        if (p) return m[3] ? txo_pkg::OUT_CWP : txo_pkg::OUT_POS;
        if (n) return m[3] ? txo_pkg::OUT_CWN : txo_pkg::OUT_NEG;
        return m[3] ? txo_pkg::OUT_HIZ : txo_pkg::OUT_RTZ;
    endfunction

    function automatic logic illegal(input int p, input int n, input int w);
        if (w < 2) return 1'b1;
        if (p + n == 1) return 1'b1;
        if (p + n >= 2 && (w - 2 * p < 2 || w - 2 * n < 2)) return 1'b1;
        return 1'b0;
    endfunction

    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        report_and_stop();
    end

    initial begin
        txo_pkg::txo_out_e e;
        int  n;
        int  lp[11] = '{1, 0, 0, 0, 0, 3, 3, 2, 2, 0, 127};
        int  ln[11] = '{0, 1, 0, 0, 0, 3, 3, 4, 4, 0, 0};
        int  lw[11] = '{20, 20, 1, 0, 2, 8, 7, 10, 9, 511, 511};
        logic [4:0] codes[4] = '{5'h01, 5'h16, 5'h17, 5'h1f};
        int  ks[4] = '{8, 288, 288, 288};
        logic [7:0] pc[3] = '{8'h72, 8'h75, 8'h76};
        int  pe[3] = '{6, 10, 6};
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        #1 chk(16'({st, damp, rsw}), 16'({txo_pkg::OUT_HIZ, 2'b10}));
        rd(3'h5, 7'h00);
        for (int i = 0; i < 16; i++) begin
            setm({4'b0011, 4'(i)});
            e = exp_st(4'(i));
            chk(16'(st), 16'(e));
            chk(16'({damp, ind_out, cw_en, rsw, zsw}), 16'({e != txo_pkg::OUT_RX,
                e == txo_pkg::OUT_RX && i < 8, i >= 8, {2{e == txo_pkg::OUT_RX}}}));
            if (e == txo_pkg::OUT_HIZ) chk(16'({p_fet, n_fet}), 16'h0000);
            chk(16'({cwp, cwn}),
                16'({e == txo_pkg::OUT_CWP, e == txo_pkg::OUT_CWN}));
        end
        // program access and disabled chip both park the channel, with the indicator raised
        @(posedge clk_in);
        rx_ind <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            setm(i == 0 ? 8'h20 : 8'h1f);
            chk(16'({st, p_fet, n_fet, rsw, damp}), 16'({txo_pkg::OUT_HIZ, 4'b0001}));
        end
        @(posedge clk_in);
        rx_ind <= 1'b0;
        setm(8'h30);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            dcode <= codes[i];
            @(posedge clk_in);
            rx_ind <= 1'b1;
            n = 0;
            do begin
                @(posedge clk_in);
                #1 n++;
            end while (rsw !== 1'b1 && n < 400);
            chk(16'(n), 16'(ks[i] + 1));
            chk(16'({rsw, zsw, damp}), 16'h0006);
            @(posedge clk_in);
            rx_ind <= 1'b0;
            repeat (2) @(posedge clk_in);
            #1 chk(16'(rsw), 16'h0000);
        end
        for (int i = 0; i < 8; i++) wr(3'(i), 7'h7f - 7'(i * 5));
        for (int i = 0; i < 8; i++) rd(3'(i), 7'h7f - 7'(i * 5));
        // wave 1 carries the cases while wave 0 keeps other values
        for (int i = 0; i < 11; i++) begin
            setm(8'h70);
            wr(3'h1, 7'(lp[i]));
            wr(3'h5, 7'(ln[i]));
            width <= 9'(lw[i]);
            setm(8'h72);
            e = illegal(lp[i], ln[i], lw[i]) ? txo_pkg::OUT_RTZ : txo_pkg::OUT_POS;
            chk(16'({frtz, st}), 16'({e == txo_pkg::OUT_RTZ, e}));
        end
        setm(8'h70);
        wr(3'h1, 7'h02);
        wr(3'h5, 7'h00);
        width <= 9'h00a;
        for (int i = 0; i < 3; i++) begin
            setm(pc[i]);
            n = 0;
            repeat (10) begin
                @(posedge clk_in);
                #1 n += (st == txo_pkg::OUT_NEG) ? int'(n_fet) : int'(p_fet);
            end
            chk(16'(n), 16'(pe[i]));
        end
        report_and_stop();
    end
endmodule
